// [core/arbiter_defs.vh]
// Constants for the dual-port serial memory arbiter and configuration block
`ifndef ARBITER_DEFS_VH
`define ARBITER_DEFS_VH

// Bus addresses, upper seven bits of the address byte
`define MEM_DEV_ADDR     7'h50
`define CFG_DEV_ADDR     7'h31
// Full address byte of the segment pointer (write only)
`define SEG_WR_ADDR      8'h60

// Configuration register fields and erased value
`define CFG_SINGLE_BANK  0
`define CFG_PICK_LOW     1
`define CFG_PICK_HIGH    2
`define CFG_WRITE_PERMIT 3
`define CFG_RESET        8'hFF

// Idle release time and its count at the core clock
`define CLK_FREQ_HZ      100000000
`define ARB_IDLE_MS      1000
`define ARB_IDLE_CYCLES  ((`CLK_FREQ_HZ / 1000) * `ARB_IDLE_MS)

`endif

// [core/dual_port_eeprom_arbiter_config.v]
// Two serial slave ports sharing one memory, with arbitration and configuration register
//
// Contract
// [RULE_01] Both clock lines high: no line pulled low
// [RULE_02] Start on one port holds other clock low
// [RULE_03] Release after one second of initiator high
// [RULE_04] Held-off master waits for clock release
// [RULE_05] Single-bank flag: 0 two banks, 1 one
// [RULE_06] Bank from pick bits or select pin
// [RULE_07] Monitor writes need write-permit bit set
// [RULE_08] Display port writes always accepted
// [RULE_09] Config written at 62h, read at 63h
// [RULE_10] Config write: address, dummy, then data byte
// [RULE_11] Write-only segment pointer at address 60h
// [RULE_12] Display port: segment bits pick 256-byte segment
// [RULE_13] Sequential reads wrap within the segment
// [RULE_14] Config register resets to all ones
// [RULE_15] Idle counter restarts on any low clock; code restarts it only on the owning port's low clock
// [RULE_16] Segment written, then repeated start access
`include "arbiter_defs.vh"
`default_nettype none

module serial_port (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Serial pins
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  // Memory and configuration side
  input  wire       write_allow,
  input  wire [7:0] rd_data,
  input  wire [7:0] cfg_data,
  output wire       start_pulse,
  output wire       scl_level,
  output reg  [7:0] offset_r,
  output reg  [1:0] seg_r,
  output reg  [7:0] wr_data_r,
  output reg        mem_wr_r,
  output reg        cfg_wr_r
);
  localparam S_IDLE  = 3'd0;
  localparam S_RX    = 3'd1;
  localparam S_ACK   = 3'd2;
  localparam S_TX    = 3'd3;
  localparam S_TXACK = 3'd4;
  localparam T_MEM   = 2'd0;
  localparam T_SEG   = 2'd1;
  localparam T_CFG   = 2'd2;

  reg  [2:0] scl_sync_r;
  reg  [2:0] sda_sync_r;
  reg  [2:0] state_r;
  reg  [7:0] shift_r;
  reg  [3:0] bit_r;
  reg  [1:0] tgt_r;
  reg  [1:0] idx_r;
  reg        rd_r;
  reg        first_r;
  reg        got_r;
  reg        oe_r;

  // Two-stage synchronisers, third stage only for edge detection
  always @(posedge clk) begin
    if (rst) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
    end
  end

  wire scl_s  = scl_sync_r[1];
  wire sda_s  = sda_sync_r[1];
  wire rise   = scl_s & ~scl_sync_r[2];
  wire fall   = ~scl_s & scl_sync_r[2];
  wire start  = scl_s & scl_sync_r[2] & sda_sync_r[2] & ~sda_s;
  wire stop   = scl_s & scl_sync_r[2] & ~sda_sync_r[2] & sda_s;
  wire hit_mem = (shift_r[7:1] == `MEM_DEV_ADDR);
  wire hit_seg = (shift_r == `SEG_WR_ADDR);
  wire hit_cfg = (shift_r[7:1] == `CFG_DEV_ADDR);

  assign start_pulse = start;
  assign scl_level   = scl_s;
  assign sda_out     = 1'b0;
  assign sda_oe      = oe_r;

  // Byte engine: address, acknowledge, receive and transmit
  always @(posedge clk) begin
    if (rst) begin
      state_r   <= S_IDLE;
      shift_r   <= 8'h00;
      bit_r     <= 4'h0;
      tgt_r     <= T_MEM;
      idx_r     <= 2'd0;
      rd_r      <= 1'b0;
      first_r   <= 1'b0;
      got_r     <= 1'b0;
      oe_r      <= 1'b0;
      offset_r  <= 8'h00;
      seg_r     <= 2'd0;
      wr_data_r <= 8'h00;
      mem_wr_r  <= 1'b0;
      cfg_wr_r  <= 1'b0;
    end else begin
      mem_wr_r <= 1'b0;
      cfg_wr_r <= 1'b0;
      // Offset steps after each stored byte, 8 bits so it wraps in segment
      if (mem_wr_r)
        offset_r <= offset_r + 8'h01; // RULE_13
      if (start) begin
        state_r <= S_RX;
        bit_r   <= 4'h0;
        first_r <= 1'b1;
        idx_r   <= 2'd0;
        got_r   <= 1'b0;
        oe_r    <= 1'b0;
      end else if (stop) begin
        // Pointer is volatile; it survives a repeated start and clears at the stop
        state_r <= S_IDLE;
        oe_r    <= 1'b0;
        seg_r   <= 2'd0; // RULE_16
      end else begin
        case (state_r)
          S_RX: begin
            if (rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_r   <= bit_r + 4'h1;
              if (bit_r == 4'h7)
                got_r <= 1'b1;
            end else if (fall && got_r) begin
              got_r <= 1'b0;
              bit_r <= 4'h0;
              if (first_r) begin
                first_r <= 1'b0;
                rd_r    <= shift_r[0];
                if (hit_mem) begin
                  tgt_r   <= T_MEM;
                  state_r <= S_ACK;
                  oe_r    <= 1'b1;
                end else if (hit_seg) begin
                  tgt_r   <= T_SEG; // RULE_11
                  state_r <= S_ACK;
                  oe_r    <= 1'b1;
                end else if (hit_cfg) begin
                  tgt_r   <= T_CFG; // RULE_09
                  state_r <= S_ACK;
                  oe_r    <= 1'b1;
                end else begin
                  // Foreign address, or 61h: no acknowledge
                  state_r <= S_IDLE;
                end
              end else begin
                if (idx_r != 2'd2)
                  idx_r <= idx_r + 2'd1;
                state_r <= S_ACK;
                oe_r    <= 1'b1;
                case (tgt_r)
                  T_SEG: seg_r <= shift_r[1:0]; // RULE_12
                  T_CFG: begin
                    // First byte after the address is a dummy
                    if (idx_r != 2'd0) begin
                      wr_data_r <= shift_r;
                      cfg_wr_r  <= 1'b1; // RULE_10
                    end
                  end
                  default: begin
                    if (idx_r == 2'd0) begin
                      offset_r <= shift_r;
                    end else if (write_allow) begin
                      wr_data_r <= shift_r;
                      mem_wr_r  <= 1'b1; // RULE_07
                    end else begin
                      state_r <= S_IDLE; // RULE_07
                      oe_r    <= 1'b0;
                    end
                  end
                endcase
              end
            end
          end
          S_ACK: begin
            if (fall) begin
              if (rd_r) begin
                state_r <= S_TX;
                shift_r <= (tgt_r == T_CFG) ? cfg_data : rd_data; // RULE_09
                oe_r    <= (tgt_r == T_CFG) ? ~cfg_data[7] : ~rd_data[7];
                bit_r   <= 4'h1;
              end else begin
                state_r <= S_RX;
                oe_r    <= 1'b0;
              end
            end
          end
          S_TX: begin
            if (fall) begin
              if (bit_r == 4'h8) begin
                state_r <= S_TXACK;
                oe_r    <= 1'b0;
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                oe_r    <= ~shift_r[6];
                bit_r   <= bit_r + 4'h1;
              end
            end
          end
          S_TXACK: begin
            if (rise) begin
              if (!sda_s) begin
                state_r <= S_ACK;
                if (tgt_r == T_MEM)
                  offset_r <= offset_r + 8'h01; // RULE_13
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
          default: begin
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // serial_port

module dual_port_eeprom_arbiter_config #(
  parameter IDLE_CYCLES = `ARB_IDLE_CYCLES,
  parameter CNT_W       = 27
) (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Display-controller port
  input  wire display_clock_line_in,
  output wire display_clock_line_out,
  output wire display_clock_line_oe,
  input  wire display_data_line_in,
  output wire display_data_line_out,
  output wire display_data_line_oe,
  // Monitor port
  input  wire monitor_port_clock_line_in,
  output wire monitor_port_clock_line_out,
  output wire monitor_port_clock_line_oe,
  input  wire monitor_data_line_in,
  output wire monitor_data_line_out,
  output wire monitor_data_line_oe,
  // Bank selection strap
  input  wire bank_select_pin
);
  localparam OWN_NONE = 2'd0;
  localparam OWN_DISP = 2'd1;
  localparam OWN_MON  = 2'd2;

  reg  [7:0]       mem_r [0:1023];
  reg  [7:0]       bank_and_write_config_r;
  reg  [1:0]       owner_r;
  reg  [CNT_W-1:0] idle_cnt_r;
  reg  [1:0]       pin_sync_r;

  wire       d_start, d_scl, d_mem_wr, d_cfg_wr;
  wire       m_start, m_scl, m_mem_wr, m_cfg_wr;
  wire [7:0] d_off, d_wdata, m_off, m_wdata;
  wire [1:0] d_seg, m_seg;
  wire       active_upper;
  wire [9:0] d_addr;
  wire [9:0] m_addr;

  // Strap synchroniser
  always @(posedge clk) begin
    if (rst)
      pin_sync_r <= 2'b00;
    else
      pin_sync_r <= {pin_sync_r[0], bank_select_pin};
  end

  // Active bank for the monitor port
  assign active_upper = bank_and_write_config_r[`CFG_SINGLE_BANK] ? 1'b0 : // RULE_05
                        (bank_and_write_config_r[`CFG_PICK_HIGH] ?
                         bank_and_write_config_r[`CFG_PICK_LOW] : pin_sync_r[1]); // RULE_06
  assign m_addr = {active_upper, m_seg[0], m_off};
  assign d_addr = {d_seg, d_off}; // RULE_12

  serial_port u_display (
    .clk         (clk),
    .rst         (rst),
    .scl_in      (display_clock_line_in),
    .sda_in      (display_data_line_in),
    .sda_out     (display_data_line_out),
    .sda_oe      (display_data_line_oe),
    .write_allow (1'b1), // RULE_08
    .rd_data     (mem_r[d_addr]),
    .cfg_data    (bank_and_write_config_r),
    .start_pulse (d_start),
    .scl_level   (d_scl),
    .offset_r    (d_off),
    .seg_r       (d_seg),
    .wr_data_r   (d_wdata),
    .mem_wr_r    (d_mem_wr),
    .cfg_wr_r    (d_cfg_wr)
  );

  serial_port u_monitor (
    .clk         (clk),
    .rst         (rst),
    .scl_in      (monitor_port_clock_line_in),
    .sda_in      (monitor_data_line_in),
    .sda_out     (monitor_data_line_out),
    .sda_oe      (monitor_data_line_oe),
    .write_allow (bank_and_write_config_r[`CFG_WRITE_PERMIT]), // RULE_07
    .rd_data     (mem_r[m_addr]),
    .cfg_data    (bank_and_write_config_r),
    .start_pulse (m_start),
    .scl_level   (m_scl),
    .offset_r    (m_off),
    .seg_r       (m_seg),
    .wr_data_r   (m_wdata),
    .mem_wr_r    (m_mem_wr),
    .cfg_wr_r    (m_cfg_wr)
  );

  // Shared array; display wins if both ever write in one cycle
  always @(posedge clk) begin
    if (d_mem_wr)
      mem_r[d_addr] <= d_wdata;
    else if (m_mem_wr)
      mem_r[m_addr] <= m_wdata;
  end

  // Configuration register, reachable from either port
  always @(posedge clk) begin
    if (rst)
      bank_and_write_config_r <= `CFG_RESET; // RULE_14
    else if (d_cfg_wr)
      bank_and_write_config_r <= d_wdata; // RULE_09
    else if (m_cfg_wr)
      bank_and_write_config_r <= m_wdata; // RULE_09
  end

  // Arbitration: first start owns the memory until its clock idles high
  always @(posedge clk) begin
    if (rst) begin
      owner_r    <= OWN_NONE;
      idle_cnt_r <= {CNT_W{1'b0}};
    end else begin
      case (owner_r)
        OWN_NONE: begin
          idle_cnt_r <= {CNT_W{1'b0}};
          if (d_start)
            owner_r <= OWN_DISP; // RULE_02
          else if (m_start)
            owner_r <= OWN_MON; // RULE_02
        end
        OWN_DISP, OWN_MON: begin
          // Not foolproof: a slow but live master could pause for a second
          if (!((owner_r == OWN_DISP) ? d_scl : m_scl))
            idle_cnt_r <= {CNT_W{1'b0}}; // RULE_15
          else if (idle_cnt_r == IDLE_CYCLES - 1)
            owner_r <= OWN_NONE; // RULE_03
          else
            idle_cnt_r <= idle_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        default: owner_r <= OWN_NONE;
      endcase
    end
  end

  // Hold off the non-owning port; nothing driven while idle
  assign display_clock_line_out     = 1'b0;
  assign monitor_port_clock_line_out = 1'b0;
  assign display_clock_line_oe      = (owner_r == OWN_MON); // RULE_01
  assign monitor_port_clock_line_oe  = (owner_r == OWN_DISP); // RULE_02
endmodule // dual_port_eeprom_arbiter_config

`default_nettype wire

// [dv/arb_checker.sv]
// Arbitration checker for the dual-port memory block
`default_nettype none
module arb_checker #(
  parameter int IDLE_CYCLES = 2000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wire levels seen at the pins
  input wire logic display_clock_line_in,
  input wire logic display_data_line_in,
  input wire logic monitor_port_clock_line_in,
  input wire logic monitor_data_line_in,
  // Pulls driven by the block
  input wire logic display_clock_line_oe,
  input wire logic monitor_port_clock_line_oe,
  input wire logic monitor_data_line_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic sda_d_r;
  logic sda_m_r;
  logic seen_r;
  int   hi_d_r;
  int   hi_m_r;
  wire  st_d = display_clock_line_in & sda_d_r & ~display_data_line_in;
  wire  st_m = monitor_port_clock_line_in & sda_m_r & ~monitor_data_line_in;
  // High-run counters; a low clock or a start restarts them
  always @(posedge clk) begin
    sda_d_r <= display_data_line_in;
    sda_m_r <= monitor_data_line_in;
    hi_d_r  <= (display_clock_line_in & ~st_d) ? hi_d_r + 1 : 0;
    hi_m_r  <= (monitor_port_clock_line_in & ~st_m) ? hi_m_r + 1 : 0;
    seen_r  <= ~rst & (seen_r | st_d | st_m);
  end
  sequence s_start_d;
    display_clock_line_in && $fell(display_data_line_in);
  endsequence
  sequence s_start_m;
    monitor_port_clock_line_in && $fell(monitor_data_line_in);
  endsequence
  a_idle_no_hold:
    assert property (!seen_r |-> !(display_clock_line_oe | monitor_port_clock_line_oe))
      else $error("clock line pulled before any start");
  a_start_holds_mon:
    assert property (s_start_d |-> ##[1:6] monitor_port_clock_line_oe)
      else $error("monitor clock not held after display start");
  a_start_holds_dsp:
    assert property (s_start_m |-> ##[1:6] display_clock_line_oe)
      else $error("display clock not held after monitor start");
  a_one_owner:
    assert property (!(display_clock_line_oe && monitor_port_clock_line_oe))
      else $error("both clock lines held");
  a_rel_mon_idle:
    assert property ($fell(monitor_port_clock_line_oe) |-> hi_d_r >= IDLE_CYCLES
                     && hi_d_r <= IDLE_CYCLES + 8)
      else $error("monitor clock released at wrong idle count");
  a_rel_dsp_idle:
    assert property ($fell(display_clock_line_oe) |-> hi_m_r >= IDLE_CYCLES
                     && hi_m_r <= IDLE_CYCLES + 8)
      else $error("display clock released at wrong idle count");
  a_hold_bounded:
    assert property ((hi_d_r <= IDLE_CYCLES + 8 || !monitor_port_clock_line_oe)
                     && (hi_m_r <= IDLE_CYCLES + 8 || !display_clock_line_oe))
      else $error("clock line held past idle time");
  a_held_port_quiet:
    assert property (monitor_port_clock_line_oe |-> !monitor_data_line_oe)
      else $error("held monitor port drives data");
endmodule // arb_checker

bind dual_port_eeprom_arbiter_config arb_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk (
  .clk                        (clk),
  .rst                        (rst),
  .display_clock_line_in      (display_clock_line_in),
  .display_data_line_in       (display_data_line_in),
  .monitor_port_clock_line_in (monitor_port_clock_line_in),
  .monitor_data_line_in       (monitor_data_line_in),
  .display_clock_line_oe      (display_clock_line_oe),
  .monitor_port_clock_line_oe (monitor_port_clock_line_oe),
  .monitor_data_line_oe       (monitor_data_line_oe)
);
`default_nettype wire

// [dv/i2c_master_model.sv]
// Open-drain serial master for one port of the memory block
`default_nettype none
module i2c_master_model (
  // Timing reference
  input  wire logic clk,
  // Resolved wire levels
  input  wire logic scl,
  input  wire logic sda,
  // Pulls, high while this master holds the line low
  output var  logic scl_oe,
  output var  logic sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // Both lines released at start
  initial begin
    scl_oe = 1'h0;
    sda_oe = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Release clock; a held-off line stalls here until freed
  task automatic rise();
    scl_oe = 1'h0;
    tick(1);
    for (int k = 0; k < 50000 && scl !== 1'h1; k++) tick(1);
    tick(6);
  endtask
  // Data moves a few clocks after the fall so sync order is kept
  task automatic bit_io(input logic b, output logic r);
    tick(3);
    sda_oe = ~b;
    tick(3);
    rise();
    r = sda;
    scl_oe = 1'h1;
  endtask
  task automatic start();
    tick(3);
    sda_oe = 1'h0;
    tick(3);
    rise();
    sda_oe = 1'h1;
    tick(6);
    scl_oe = 1'h1;
  endtask
  task automatic stop();
    tick(3);
    sda_oe = 1'h1;
    tick(3);
    rise();
    sda_oe = 1'h0;
    tick(6);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic n, output logic [7:0] r,
                         output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(n, a);
  endtask
endmodule // i2c_master_model
`default_nettype wire

// [dv/dual_port_eeprom_arbiter_config_tb.sv]
// Self-checking bench for the dual-port memory arbiter
`default_nettype none
module dual_port_eeprom_arbiter_config_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int IDLE = 2000;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic bank_select_pin = 1'h0;
  int   num_errors = 0;
  int   num_checks = 0;
  wire  d_scl_oe, d_sda_oe, m_scl_oe, m_sda_oe;
  wire  display_clock_line_oe, display_data_line_oe;
  wire  monitor_port_clock_line_oe, monitor_data_line_oe;
  // Driven levels of the four open-drain outputs, all must be low
  wire  [3:0] line_out;
  // Open-drain wires with pull-ups
  wire  d_scl = ~(d_scl_oe | display_clock_line_oe);
  wire  d_sda = ~(d_sda_oe | display_data_line_oe);
  wire  m_scl = ~(m_scl_oe | monitor_port_clock_line_oe);
  wire  m_sda = ~(m_sda_oe | monitor_data_line_oe);
  dual_port_eeprom_arbiter_config #(.IDLE_CYCLES(IDLE), .CNT_W(27)) dut (
    .clk(clk), .rst(rst), .bank_select_pin(bank_select_pin),
    .display_clock_line_in(d_scl), .display_clock_line_out(line_out[0]),
    .display_clock_line_oe(display_clock_line_oe),
    .display_data_line_in(d_sda), .display_data_line_out(line_out[1]),
    .display_data_line_oe(display_data_line_oe),
    .monitor_port_clock_line_in(m_scl), .monitor_port_clock_line_out(line_out[2]),
    .monitor_port_clock_line_oe(monitor_port_clock_line_oe),
    .monitor_data_line_in(m_sda), .monitor_data_line_out(line_out[3]),
    .monitor_data_line_oe(monitor_data_line_oe));
  i2c_master_model dsp (.clk(clk), .scl(d_scl), .sda(d_sda), .scl_oe(d_scl_oe), .sda_oe(d_sda_oe));
  i2c_master_model mon (.clk(clk), .scl(m_scl), .sda(m_sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  // Core clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic st(input bit p);
    if (p) mon.start();
    else dsp.start();
  endtask
  task automatic sp(input bit p);
    if (p) mon.stop();
    else dsp.stop();
  endtask
  // Write one byte and compare the acknowledge bit
  task automatic wb(input bit p, input logic [7:0] d, input logic n);
    logic [7:0] r;
    logic       a;
    if (p) mon.byte_io(d, 1'h1, r, a);
    else dsp.byte_io(d, 1'h1, r, a);
    check({7'h00, a}, {7'h00, n});
  endtask
  task automatic rb(input bit p, input logic n, output logic [7:0] r);
    logic a;
    if (p) mon.byte_io(8'hFF, n, r, a);
    else dsp.byte_io(8'hFF, n, r, a);
  endtask
  // Segment pointer, then repeated start with the offset
  task automatic at(input bit p, input logic [7:0] s, input logic [7:0] o);
    st(p);
    wb(p, 8'h60, 1'h0);
    wb(p, s, 1'h0);
    st(p);
    wb(p, 8'hA0, 1'h0);
    wb(p, o, 1'h0);
  endtask
  task automatic rd(input bit p, input logic [7:0] s, input logic [7:0] o,
                    output logic [7:0] r);
    at(p, s, o);
    st(p);
    wb(p, 8'hA1, 1'h0);
    rb(p, 1'h1, r);
    sp(p);
  endtask
  task automatic wr(input bit p, input logic [7:0] s, input logic [7:0] o,
                    input logic [7:0] d, input logic n);
    at(p, s, o);
    wb(p, d, n);
    sp(p);
  endtask
  task automatic cw(input bit p, input logic [7:0] v);
    st(p);
    wb(p, 8'h62, 1'h0);
    wb(p, 8'h00, 1'h0);
    wb(p, v, 1'h0);
    sp(p);
  endtask
  task automatic cr(input bit p, output logic [7:0] r);
    st(p);
    wb(p, 8'h63, 1'h0);
    rb(p, 1'h1, r);
    sp(p);
  endtask
  task automatic t_idle();
    logic [7:0] r;
    int         n;
    check({7'h00, display_clock_line_oe | monitor_port_clock_line_oe}, 8'h00);
    check({4'h0, line_out}, 8'h00);
    cr(1'h0, r);
    check(r, 8'hFF);
    check({7'h00, monitor_port_clock_line_oe}, 8'h01);
    for (n = 0; n < 3 * IDLE && monitor_port_clock_line_oe === 1'h1; n++) @(negedge clk);
    // Wait starts 13 clocks after the line rose; sync adds about 2 more
    check({7'h00, n + 13 >= IDLE && n + 13 <= IDLE + 4}, 8'h01);
    $display("test idle done");
  endtask
  // Lower bank is display segment 0, upper bank display segment 2
  task automatic t_bank();
    logic [7:0] r;
    logic [7:0] cfg [5] = '{8'hA0, 8'hA0, 8'hA4, 8'hA6, 8'hA7};
    logic [4:0] pin = 5'h1A;
    logic [4:0] up = 5'h0A;
    wr(1'h0, 8'h00, 8'h40, 8'h11, 1'h0);
    wr(1'h0, 8'h02, 8'h40, 8'h22, 1'h0);
    for (int i = 0; i < 5; i++) begin
      cw(1'h0, cfg[i]);
      bank_select_pin = pin[i];
      rd(1'h1, 8'h00, 8'h40, r);
      check(r, up[i] ? 8'h22 : 8'h11);
    end
    cr(1'h1, r);
    check(r, 8'hA7);
    $display("test bank done");
  endtask
  // Permit bit clear, then set; display writes regardless
  task automatic t_permit();
    logic [7:0] r;
    wr(1'h0, 8'h00, 8'h05, 8'h33, 1'h0);
    wr(1'h1, 8'h00, 8'h05, 8'h5A, 1'h1);
    rd(1'h0, 8'h00, 8'h05, r);
    check(r, 8'h33);
    cw(1'h0, 8'hAF);
    wr(1'h1, 8'h00, 8'h05, 8'h5A, 1'h0);
    rd(1'h0, 8'h00, 8'h05, r);
    check(r, 8'h5A);
    $display("test permit done");
  endtask
  task automatic t_wrap();
    logic [7:0] r;
    st(1'h0);
    wb(1'h0, 8'h61, 1'h1);
    sp(1'h0);
    at(1'h0, 8'h03, 8'hFF);
    wb(1'h0, 8'hC3, 1'h0);
    wb(1'h0, 8'h3C, 1'h0);
    sp(1'h0);
    at(1'h0, 8'h03, 8'hFF);
    st(1'h0);
    wb(1'h0, 8'hA1, 1'h0);
    rb(1'h0, 1'h0, r);
    check(r, 8'hC3);
    rb(1'h0, 1'h1, r);
    check(r, 8'h3C);
    sp(1'h0);
    $display("test wrap done");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'h0;
    repeat (6) @(negedge clk);
    t_idle();
    t_bank();
    t_permit();
    t_wrap();
    complete_run();
  end
  // Watchdog, well past the expected run of about 43k cycles
  initial begin
    #900us;
    num_errors++;
    complete_run();
  end
endmodule // dual_port_eeprom_arbiter_config_tb
`default_nettype wire
